// ==== src/mpe_pkg.sv ====
/*
 * Shared constants and types for the message payload end-of-data adapter.
 * Assumes one port clock (ref_clk, 200 MHz) and a synchronous active-high reset.
 */
package mpe_pkg;

	// ******************************************************************
	// Widths and constants
	// ******************************************************************
	localparam int unsigned OPCODE_W    = 8;
	localparam int unsigned LEN_W       = 16;
	localparam int unsigned COUNT_W     = 32;
	localparam int unsigned IFACE_VER_W = 4;
	localparam logic [OPCODE_W-1:0]    FIRST_OPCODE  = 8'h00;
	localparam logic [IFACE_VER_W-1:0] IFACE_VER_NEW = 4'h2;
	localparam logic [1:0]             SIZE_MAX_LOG2 = 2'h3;

	// Consumer-side adapter states
	typedef enum logic [1:0] {
		MPE_IDLE,
		MPE_PASS,
		MPE_INJECT,
		MPE_DONE
	} mpe_state_t;

endpackage : mpe_pkg

// ==== src/mpe_link_if.sv ====
/*
 * Link between the producer adapter and the consumer adapter.
 * Assumes both ends share ref_clk; the testbench joins them.
 */
`timescale 1ns/1ps
interface mpe_link_if (
	input wire logic ref_clk
);
	logic                          valid;
	logic                          ready;
	logic [7:0]                    data;
	logic                          som;
	logic                          eom;
	logic                          empty;
	logic [mpe_pkg::OPCODE_W-1:0]  opcode;
	logic                          end_of_data;

	modport producer (
		output valid,
		input  ready,
		output data,
		output som,
		output eom,
		output empty,
		output opcode,
		output end_of_data
	);
	modport consumer (
		input  valid,
		output ready,
		input  data,
		input  som,
		input  eom,
		input  empty,
		input  opcode,
		input  end_of_data
	);
endinterface : mpe_link_if

// ==== src/mpe_producer_end.sv ====
/*
 * Producer end: serialises a worker's payload values into the aligned
 * little-endian byte stream and raises the end-of-data sideband.
 * One field (a scalar, a structure member, an array element or a sequence
 * count) is taken per handshake; padding ahead of it is worked out here from
 * the running byte offset and the alignment that the worker declares.
 * A legacy worker signals end with an empty opcode-zero message; wr_end is
 * then ignored, since such a worker has no separate end output.
 * Once end-of-data is out, wr_ready stays low until reset: the link has no
 * way to carry bytes behind a standing end flag.
 * Limitation: the offset counter is 16 bits wide, so alignment is only kept
 * for messages shorter than 64 KiB; fields wider than eight bytes are split
 * by the worker.
 * Assumes the worker holds its value stable while wr_valid and not wr_ready.
 * Assumes the worker names the first field of each message with wr_first and
 * the last one with wr_last, and declares a structure's or sequence's
 * alignment on the field that opens it.
 * Assumes the consumer end sits on the same ref_clk and the same reset.
 */
`timescale 1ns/1ps
module mpe_producer_end (
	input  wire logic                                ref_clk,
	input  wire logic                                reset,
	input  wire logic [mpe_pkg::IFACE_VER_W-1:0]     iface_version,
	input  wire logic                                wr_valid,
	output logic                                     wr_ready,
	input  wire logic [63:0]                         wr_value,
	input  wire logic [1:0]                          wr_size_log2,
	input  wire logic [1:0]                          wr_align_log2,
	input  wire logic                                wr_first,
	input  wire logic                                wr_last,
	input  wire logic                                wr_empty,
	input  wire logic [mpe_pkg::OPCODE_W-1:0]        wr_opcode,
	input  wire logic                                wr_end,
	mpe_link_if.producer                             link
);

	// ******************************************************************
	// State
	// ******************************************************************
	// Whole state in one register: the field being sent, its pad and byte
	// counts, the running offset within the message, the link's output
	// register, and the two end flags (seen from the worker, shown on the link)
	typedef struct packed {
		logic                         busy;
		logic [63:0]                  shreg;
		logic [3:0]                   left;
		logic [2:0]                   pad;
		logic [15:0]                  offset;
		logic                         first;
		logic                         last;
		logic                         valid;
		logic [7:0]                   data;
		logic                         som;
		logic                         eom;
		logic                         empty;
		logic [mpe_pkg::OPCODE_W-1:0] opcode;
		logic                         end_seen;
		logic                         end_out;
		logic                         ready;
	} mpe_prod_st_t;

	mpe_prod_st_t st_q, st_d;
	logic          legacy;     // Worker predates the sideband end flag
	logic [15:0]   amask;      // Alignment minus one, as an offset mask
	logic          out_free;   // Link register empty or being taken
	logic          take;       // Field taken at this edge
	logic          end_msg;    // Legacy empty opcode-zero message
	logic [2:0]    pad_need;   // Pad bytes ahead of the new field
	logic [3:0]    size_bytes; // Value bytes in the new field

	// ******************************************************************
	// Field decode
	// ******************************************************************
	// Alignment is counted from message start, so the first field never pads
	assign legacy     = (iface_version < mpe_pkg::IFACE_VER_NEW);
	assign amask      = 16'((16'h0001 << wr_align_log2) - 16'h0001);
	// A byte may be loaded while the consumer takes the one before it
	assign out_free   = !st_q.valid || link.ready;
	// A new field waits until the previous one has gone out in full
	assign take       = !st_q.busy && st_q.ready && wr_valid;
	// For a legacy worker this message means end; it never reaches the link
	assign end_msg    = wr_empty && legacy && (wr_opcode == mpe_pkg::FIRST_OPCODE);
	// Distance to the next multiple of the alignment; seven bytes at most
	assign pad_need   = wr_first ? 3'h0 : 3'((16'h0000 - st_q.offset) & amask);
	// One, two, four or eight value bytes
	assign size_bytes = 4'(4'h1 << wr_size_log2);

	// ******************************************************************
	// Byte emission
	// ******************************************************************
	// Padding first, then value bytes low to high; one byte per cycle at most
	always_comb begin
		st_d = st_q;
		// The link register empties on the edge the consumer takes it
		if (st_q.valid && link.ready) begin
			st_d.valid = 1'b0;
		end
		// A legacy worker cannot raise the flag directly; it sends a message
		if (wr_end && !legacy) begin
			st_d.end_seen = 1'b1;
		end
		// Field taken: ready drops until its last byte is out
		if (take) begin
			st_d.ready = 1'b0;
			if (end_msg) begin
				st_d.end_seen = 1'b1;
			end else if (wr_empty) begin
				// Argumentless operation: one dummy byte that carries the opcode
				st_d.busy  = 1'b1;
				st_d.left  = 4'h0;
				st_d.pad   = 3'h0;
				st_d.first = 1'b1;
				st_d.last  = 1'b1;
				st_d.opcode = wr_opcode;
			end else begin
				st_d.busy   = 1'b1;
				st_d.shreg  = wr_value;
				st_d.left   = size_bytes;
				st_d.pad    = pad_need;
				st_d.first  = wr_first;
				st_d.last   = wr_last;
				st_d.opcode = wr_opcode;
				// A first field restarts the offset; its own pad is zero
				if (wr_first) begin
					st_d.offset = 16'h0000;
				end
			end
		end else if (st_q.busy && out_free) begin
			// Next byte into the link register; offset counts pads and values
			st_d.valid  = 1'b1;
			st_d.som    = st_q.first;
			st_d.empty  = (st_q.left == 4'h0);
			st_d.first  = 1'b0;
			st_d.offset = st_q.offset + 16'h0001;
			// Left at zero only for an argumentless message
			if (st_q.left == 4'h0) begin
				st_d.data = 8'h00;
				st_d.eom  = 1'b1;
				st_d.busy = 1'b0;
				st_d.ready = 1'b1;
			end else if (st_q.pad != 3'h0) begin
				// Pad content is free; zero keeps the stream easy to read
				st_d.data = 8'h00;
				st_d.eom  = 1'b0;
				st_d.pad  = st_q.pad - 3'h1;
			end else begin
				// Least significant byte first, whatever the field's width
				st_d.data  = st_q.shreg[7:0];
				st_d.shreg = {8'h00, st_q.shreg[63:8]};
				st_d.left  = st_q.left - 4'h1;
				st_d.eom   = st_q.last && (st_q.left == 4'h1);
				// Last value byte: release the worker for the next field
				if (st_q.left == 4'h1) begin
					st_d.busy  = 1'b0;
					st_d.ready = 1'b1;
				end
			end
		end else if (!st_q.busy && !st_q.ready && !wr_valid) begin
			// After a legacy end message, ready returns once wr_valid has dropped, unless end_out is set by then
			st_d.ready = 1'b1;
		end
		// ******************************************************************
		// End-of-data sideband
		// ******************************************************************
		// Waits until the last accepted byte has left and no field is pending;
		// a field taken in the same cycle goes out first
		if (st_q.end_seen && !st_d.busy && !st_d.valid) begin
			st_d.end_out = 1'b1;
		end
		// Only reset clears the flag
		if (st_q.end_out) begin
			st_d.end_out = 1'b1;
		end
		// Ready drops with the flag so that nothing slips in behind it
		if (st_d.end_out) begin
			st_d.ready = 1'b0;
		end
	end

	// ******************************************************************
	// State register
	// ******************************************************************
	// Reset clears both flags; ready comes up high so a field may follow at once
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st_q <= '0;
			st_q.ready <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// ******************************************************************
	// Outputs
	// ******************************************************************
	// Every output is a field of the state register, with no path from an input
	assign wr_ready         = st_q.ready;
	assign link.valid       = st_q.valid;
	assign link.data        = st_q.data;
	assign link.som         = st_q.som;
	assign link.eom         = st_q.eom;
	assign link.empty       = st_q.empty;
	assign link.opcode      = st_q.opcode;
	assign link.end_of_data = st_q.end_out;

endmodule : mpe_producer_end

// ==== src/mpe_consumer_end.sv ====
/*
 * Consumer end: passes link bytes to the worker, converts end-of-data
 * into an empty opcode-zero message for legacy workers, and forwards
 * the flag to the worker's own output unless it handles it itself.
 * Assumes the producer end drives the link on the same ref_clk.
 */
`timescale 1ns/1ps
module mpe_consumer_end (
	input  wire logic                                ref_clk,
	input  wire logic                                reset,
	input  wire logic [mpe_pkg::IFACE_VER_W-1:0]     iface_version,
	input  wire logic                                worker_handles_end_flag,
	mpe_link_if.consumer                             link,
	output logic                                     rd_valid,
	input  wire logic                                rd_ready,
	output logic [7:0]                               rd_data,
	output logic                                     rd_som,
	output logic                                     rd_eom,
	output logic                                     rd_empty,
	output logic [mpe_pkg::OPCODE_W-1:0]             rd_opcode,
	output logic                                     rd_end,
	output logic                                     fwd_end
);

	// ******************************************************************
	// State
	// ******************************************************************
	typedef struct packed {
		mpe_pkg::mpe_state_t          state;
		logic                         valid;
		logic [7:0]                   data;
		logic                         som;
		logic                         eom;
		logic                         empty;
		logic [mpe_pkg::OPCODE_W-1:0] opcode;
		logic                         end_in;
		logic                         fwd;
		logic                         end_up;
		logic                         ready;
	} mpe_cons_st_t;

	mpe_cons_st_t st_q, st_d;
	logic         legacy;
	logic         slot_free;

	assign legacy    = (iface_version < mpe_pkg::IFACE_VER_NEW);
	assign slot_free = !st_q.valid || rd_ready;

	// One-byte slot between link and worker; ready only when it can take a byte
	always_comb begin
		st_d = st_q;
		st_d.ready = 1'b0;
		if (st_q.valid && rd_ready) begin
			st_d.valid = 1'b0;
		end
		case (st_q.state)
			mpe_pkg::MPE_IDLE, mpe_pkg::MPE_PASS: begin
				if (link.valid && st_q.ready) begin
					st_d.valid  = 1'b1;
					st_d.data   = link.data;
					st_d.som    = link.som;
					st_d.eom    = link.eom;
					st_d.empty  = link.empty;
					st_d.opcode = link.opcode;
					st_d.state  = link.eom ? mpe_pkg::MPE_IDLE : mpe_pkg::MPE_PASS;
				end else if (link.end_of_data && st_q.state == mpe_pkg::MPE_IDLE && !link.valid) begin
					st_d.end_in = 1'b1;
					st_d.state  = legacy ? mpe_pkg::MPE_INJECT : mpe_pkg::MPE_DONE;
				end
				st_d.ready = (st_d.state != mpe_pkg::MPE_INJECT) && (st_d.state != mpe_pkg::MPE_DONE)
					&& (!st_d.valid || (st_q.valid && rd_ready && !(link.valid && st_q.ready)));
			end
			mpe_pkg::MPE_INJECT: begin
				if (slot_free) begin
					st_d.valid  = 1'b1;
					st_d.data   = 8'h00;
					st_d.som    = 1'b1;
					st_d.eom    = 1'b1;
					st_d.empty  = 1'b1;
					st_d.opcode = mpe_pkg::FIRST_OPCODE;
					st_d.state  = mpe_pkg::MPE_DONE;
				end
			end
			mpe_pkg::MPE_DONE: begin
				st_d.end_in = 1'b1;
				// Flag shown to the worker only once the slot has been drained
				if (!legacy && !st_q.valid) begin
					st_d.end_up = 1'b1;
				end
			end
			default: begin
				st_d.state = mpe_pkg::MPE_IDLE;
			end
		endcase
		// Automatic forwarding unless the worker takes care of the flag
		if (st_q.end_in && !worker_handles_end_flag) begin
			st_d.fwd = 1'b1;
		end
		if (st_q.fwd) begin
			st_d.fwd = 1'b1;
		end
		if (st_q.end_up) begin
			st_d.end_up = 1'b1;
		end
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st_q <= '0;
			st_q.ready <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign link.ready = st_q.ready;
	assign rd_valid   = st_q.valid;
	assign rd_data    = st_q.data;
	assign rd_som     = st_q.som;
	assign rd_eom     = st_q.eom;
	assign rd_empty   = st_q.empty;
	assign rd_opcode  = st_q.opcode;
	assign rd_end     = st_q.end_up;
	assign fwd_end    = st_q.fwd;

endmodule : mpe_consumer_end

// ==== dv/mpe_link_monitor.sv ====
/*
 * Checker on the link that joins the producer and consumer ends.
 * Assumes the bench wires it to the mpe_link_if signals.
 */
`timescale 1ns/1ps
module mpe_link_monitor (
	input wire logic	ref_clk,
	input wire logic	reset,
	input wire logic	valid,
	input wire logic	ready,
	input wire logic [7:0]	data,
	input wire logic	som,
	input wire logic	eom,
	input wire logic	empty,
	input wire logic [mpe_pkg::OPCODE_W-1:0]	opcode,
	input wire logic	end_of_data
);
	// ********
	// Framing
	// ********
	logic	in_msg_q;
	logic [mpe_pkg::OPCODE_W-1:0]	op_q;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	// Opcode latched on every take; it may not move inside a message
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			in_msg_q <= 1'h0;
		end else if (valid && ready) begin
			in_msg_q <= !eom;
			op_q <= opcode;
		end
	end
	// ********
	// Properties
	// ********
	property p_end_sticky; end_of_data |=> end_of_data; endproperty
	a_end_sticky: assert property (p_end_sticky) else $error("end flag dropped");
	property p_end_quiet; end_of_data |-> !valid; endproperty
	a_end_quiet: assert property (p_end_quiet) else $error("byte after end");
	property p_hold; valid && !ready |=> valid && $stable({data, som, eom, empty, opcode}); endproperty
	a_hold: assert property (p_hold) else $error("byte changed while stalled");
	property p_start; valid && !in_msg_q |-> som; endproperty
	a_start: assert property (p_start) else $error("message without start");
	property p_mid; valid && in_msg_q |-> !som; endproperty
	a_mid: assert property (p_mid) else $error("start inside message");
	property p_opcode; valid && in_msg_q |-> opcode == op_q; endproperty
	a_opcode: assert property (p_opcode) else $error("opcode moved");
	property p_empty; valid && empty |-> som && eom && data == 8'h00; endproperty
	a_empty: assert property (p_empty) else $error("bad empty message");
	property p_long; valid && eom && !som |-> !empty; endproperty
	a_long: assert property (p_long) else $error("empty flag on long message");
	c_empty: cover property (valid && ready && empty);
	c_end: cover property ($rose(end_of_data));
	c_long: cover property (valid && ready && eom && !som);
endmodule // mpe_link_monitor

// ==== dv/message_payload_eof_adapter_test.sv ====
/*
 * Bench joining both adapter ends through mpe_link_if.
 * Assumes the package, interface and design files are compiled first.
 */
`timescale 1ns/1ps
module message_payload_eof_adapter_test;
	// ********
	// Signals
	// ********
	logic	ref_clk = 1'h0;
	logic	reset, stall, handles, rd_ready, wr_valid, wr_first, wr_last, wr_empty, wr_end;
	logic [mpe_pkg::IFACE_VER_W-1:0]	ver;
	logic [63:0]	wr_value;
	logic [1:0]	wr_size_log2, wr_align_log2;
	logic [7:0]	wr_opcode, rd_opcode, rd_data;
	logic	wr_ready, rd_valid, rd_som, rd_eom, rd_empty, rd_end, fwd_end;
	logic [18:0]	got[$];
	int	bad_count, comparisons;
	mpe_link_if lk (.ref_clk(ref_clk));
	mpe_producer_end i_mpe_producer_end (.ref_clk, .reset, .iface_version(ver), .wr_valid, .wr_ready,
		.wr_value, .wr_size_log2, .wr_align_log2, .wr_first, .wr_last, .wr_empty, .wr_opcode, .wr_end, .link(lk));
	mpe_consumer_end i_mpe_consumer_end (.ref_clk, .reset, .iface_version(ver),
		.worker_handles_end_flag(handles), .link(lk), .rd_valid, .rd_ready, .rd_data, .rd_som, .rd_eom,
		.rd_empty, .rd_opcode, .rd_end, .fwd_end);
	mpe_link_monitor i_mpe_link_monitor (.ref_clk, .reset, .valid(lk.valid), .ready(lk.ready),
		.data(lk.data), .som(lk.som), .eom(lk.eom), .empty(lk.empty), .opcode(lk.opcode),
		.end_of_data(lk.end_of_data));
	// Clock, and a worker that stalls every other cycle when asked
	always #2.5 ref_clk = ~ref_clk;
	always @(negedge ref_clk) rd_ready <= !stall || !rd_ready;
	// Record every byte the worker takes
	always @(posedge ref_clk) begin
		if (rd_valid === 1'h1 && rd_ready === 1'h1) begin
			got.push_back({rd_empty, rd_som, rd_eom, rd_opcode, rd_data});
		end
	end
	// ********
	// Tasks
	// ********
	task chk(input string what, input logic [63:0] exp, seen);
		comparisons++;
		if (seen !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, seen);
			bad_count++;
		end
	endtask
	task end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// A spent wait bound ends the run at once
	task tmo(input bit ok);
		if (!ok) begin
			$display("Error wait expected 1 seen 0");
			bad_count++;
			end_of_test();
		end
	endtask
	// Held until wr_ready is seen high at a rising edge
	task put(input logic [63:0] v, input logic [1:0] sz, al, input logic f, l, e, input logic [7:0] op);
		int n;
		@(negedge ref_clk);
		{wr_value, wr_size_log2, wr_align_log2, wr_first, wr_last, wr_empty, wr_opcode} = {v, sz, al, f, l, e, op};
		wr_valid = 1'h1;
		n = 0;
		@(posedge ref_clk);
		while (wr_ready !== 1'h1 && n < 99) begin
			@(posedge ref_clk);
			n++;
		end
		tmo(n < 99);
		@(negedge ref_clk);
		wr_valid = 1'h0;
	endtask
	// Pad bytes are masked: their content is free
	task check_msg(input logic [7:0] op, input int cnt, input logic [191:0] b, input logic [23:0] pad,
		input logic emp);
		int n;
		logic [18:0] e;
		for (n = 0; n < 300 && got.size() < cnt; n++) @(negedge ref_clk);
		tmo(got.size() >= cnt);
		for (n = 0; n < cnt; n++) begin
			e = got.pop_front();
			if (pad[n]) e[7:0] = 8'h00;
			chk("byte", {emp, n == 0, n == cnt - 1, op, b[8*n +: 8]}, e);
		end
	endtask
	// Waits on rd_end, or on fwd_end when fwd is set
	task wait_hi(input bit fwd);
		int n;
		for (n = 0; n < 300 && (fwd ? fwd_end : rd_end) !== 1'h1; n++) @(negedge ref_clk);
		tmo((fwd ? fwd_end : rd_end) === 1'h1);
	endtask
	task rst;
		@(negedge ref_clk);
		reset = 1'h1;
		wr_end = 1'h0;
		repeat (8) @(negedge ref_clk);
		reset = 1'h0;
	endtask
	// ********
	// Tests
	// ********
	initial begin
		{wr_valid, wr_first, wr_last, wr_empty, wr_end, handles, stall} = 7'h00;
		{wr_value, wr_size_log2, wr_align_log2, wr_opcode} = 76'h0;
		reset = 1'h1;
		ver = mpe_pkg::IFACE_VER_NEW;
		bad_count = 0;
		comparisons = 0;
		repeat (8) @(negedge ref_clk);
		reset = 1'h0;
		stall = 1'h1;
		put(64'h01, 2'h0, 2'h0, 1'h1, 1'h0, 1'h0, 8'h03);
		put(64'h2345, 2'h1, 2'h1, 1'h0, 1'h0, 1'h0, 8'h03);
		put(64'h6789, 2'h1, 2'h1, 1'h0, 1'h0, 1'h0, 8'h03);
		put(64'hFEDCBA9876543210, 2'h3, 2'h3, 1'h0, 1'h1, 1'h0, 8'h03);
		check_msg(8'h03, 16, 192'hFEDCBA9876543210_0000678923450001, 24'h00C2, 1'h0);
		$display("payload test done");
		put(64'h1, 2'h2, 2'h2, 1'h1, 1'h0, 1'h0, 8'h00);
		put(64'hAA, 2'h0, 2'h3, 1'h0, 1'h0, 1'h0, 8'h00);
		put(64'h1122334455667788, 2'h3, 2'h3, 1'h0, 1'h1, 1'h0, 8'h00);
		check_msg(8'h00, 24, 192'h1122334455667788_00000000000000AA_0000000000000001, 24'h00FEF0, 1'h0);
		$display("sequence test done");
		put(64'h0, 2'h0, 2'h0, 1'h1, 1'h1, 1'h1, 8'h00);
		check_msg(8'h00, 1, 192'h0, 24'h0, 1'h1);
		put(64'h0, 2'h0, 2'h0, 1'h1, 1'h1, 1'h1, 8'h05);
		check_msg(8'h05, 1, 192'h0, 24'h0, 1'h1);
		chk("rd_end", 1'h0, rd_end);
		$display("empty message test done");
		stall = 1'h0;
		handles = 1'h1;
		@(negedge ref_clk);
		wr_end = 1'h1;
		wait_hi(1'b0);
		repeat (20) @(negedge ref_clk);
		chk("fwd_end", 1'h0, fwd_end);
		chk("rd_end", 1'h1, rd_end);
		chk("messages", 0, got.size());
		rst();
		chk("rd_end", 1'h0, rd_end);
		$display("end flag test done");
		ver = 4'h1;
		handles = 1'h0;
		rst();
		put(64'h0, 2'h0, 2'h0, 1'h1, 1'h1, 1'h1, 8'h00);
		wait_hi(1'b1);
		check_msg(8'h00, 1, 192'h0, 24'h0, 1'h1);
		chk("link end", 1'h1, lk.end_of_data);
		chk("rd_end", 1'h0, rd_end);
		$display("legacy test done");
		end_of_test();
	end
endmodule // message_payload_eof_adapter_test
